// *** core/filter_channel_scan_mux.sv ***
// scan sequencer of the card_select_board in a 512-channel filter crate
// assumes link pins are asynchronous to clk_sys; scan clock is much slower
//
// Functional notes
// - step all 512 channels, one per microsecond
// - two-stage select: 32 channels, 16 cards
// - counter order gives ascending RF frequency
// - isolate integrators before scanning starts
// - discharge pulse after readout, at most 100us
// - five 8-way selectors feed a sixth
// - load card, load channel, increment, SPI write
// - scan clock plus enable increments channel
// - bit-swap channel number onto buses
// - 8-bit register, two four-line SPI sets
// - adr line marks address load
// - error readback: missing cards, PLL unlock
// - per-channel offset DACs loaded serially
// - backplane carries accumulate, discharge, selects
`timescale 1ns/1ps
module filter_channel_scan_mux
    import scan_mux_pkg::*;
#(
    parameter int DISCHARGE_MAX_CYCLES = DISCHARGE_CYCLES
)
(
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic scan_clk, // link scan clock pin
    input wire logic scan_en, // link scan enable pin
    input wire logic frame_sync, // link frame sync pin
    input wire logic accumulate_in, // link accumulate pin
    input wire logic discharge_in, // link discharge pin
    input wire logic cmd_strobe, // control strobe pin
    input wire logic [1:0] cmd_op, // control operation pins
    input wire logic [CMD_DATA_W-1:0] cmd_data, // control data pins
    input wire logic [NUM_CARDS-1:0] card_fault, // wrong or missing card pins
    input wire logic [NUM_PLLS-1:0] pll_unlock, // converter pll unlock pins
    output logic [CARD_W-1:0] card_bus, // swapped card select bus
    output logic [CHAN_W-1:0] chan_bus, // swapped channel select bus
    output logic [CARD_W-1:0] video_sel, // local 16-way video select
    output logic [MUX8_SEL_W-1:0] mux8_sel, // first-level 8-way select
    output logic [MUX6_SEL_W-1:0] mux6_sel, // second-level chip select
    output logic accumulate_bp, // accumulate to filter cards
    output logic discharge_bp, // discharge to filter cards
    output logic detector_connect, // integrators tied to detectors
    output logic [SPI_SET_W-1:0] conv_spi, // converter card serial lines
    output logic [SPI_SET_W-1:0] filt_spi, // filter card serial lines
    output logic error_readback // any crate fault
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int SYNC_W = 6 + 2 + CMD_DATA_W + NUM_CARDS + NUM_PLLS;

    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_meta;
    logic [SYNC_W-1:0] pin_sync;

    assign pin_raw = {pll_unlock, card_fault, cmd_data, cmd_op, cmd_strobe,
        discharge_in, accumulate_in, frame_sync, scan_en, scan_clk};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end
                else
                begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    logic scan_clk_s;
    logic scan_en_s;
    logic frame_sync_s;
    logic accumulate_s;
    logic discharge_s;
    logic cmd_strobe_s;
    cmd_op_type cmd_op_s;
    logic [CMD_DATA_W-1:0] cmd_data_s;
    logic [NUM_CARDS-1:0] card_fault_s;
    logic [NUM_PLLS-1:0] pll_unlock_s;

    assign scan_clk_s = pin_sync[0];
    assign scan_en_s = pin_sync[1];
    assign frame_sync_s = pin_sync[2];
    assign accumulate_s = pin_sync[3];
    assign discharge_s = pin_sync[4];
    assign cmd_strobe_s = pin_sync[5];
    assign cmd_op_s = cmd_op_type'(pin_sync[7:6]);
    assign cmd_data_s = pin_sync[8 +: CMD_DATA_W];
    assign card_fault_s = pin_sync[8 + CMD_DATA_W +: NUM_CARDS];
    assign pll_unlock_s = pin_sync[8 + CMD_DATA_W + NUM_CARDS +: NUM_PLLS];

    // ************************************************************
    // edge detection state
    // ************************************************************
    logic scan_clk_prev;
    logic frame_sync_prev;
    logic cmd_strobe_prev;
    logic next_scan_clk_prev;
    logic next_frame_sync_prev;
    logic next_cmd_strobe_prev;
    logic scan_step;
    logic frame_start;
    logic cmd_take;
    logic scan_window;

    // stepping only once integrators are isolated
    assign scan_window = !accumulate_s && !discharge_s;
    assign scan_step = scan_clk_s && !scan_clk_prev && scan_en_s && scan_window;
    assign frame_start = frame_sync_s && !frame_sync_prev;
    // data pins are stable while the strobe rises, and pass the same two stages
    assign cmd_take = cmd_strobe_s && !cmd_strobe_prev;

    always_comb
    begin
        next_scan_clk_prev = scan_clk_s;
        next_frame_sync_prev = frame_sync_s;
        next_cmd_strobe_prev = cmd_strobe_s;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scan_clk_prev <= 1'b0;
            frame_sync_prev <= 1'b0;
            cmd_strobe_prev <= 1'b0;
        end
        else
        begin
            scan_clk_prev <= next_scan_clk_prev;
            frame_sync_prev <= next_frame_sync_prev;
            cmd_strobe_prev <= next_cmd_strobe_prev;
        end
    end

    // ************************************************************
    // channel and card counter
    // ************************************************************
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic spi_wr;
    logic next_spi_wr;
    logic [SPI_REG_W-1:0] spi_data;
    logic [SPI_REG_W-1:0] next_spi_data;

    // frame sync outranks commands, commands outrank scan steps
    always_comb
    begin
        next_count = count;
        next_spi_wr = 1'b0;
        next_spi_data = spi_data;
        if (frame_start)
        begin
            next_count = '0;
        end
        else if (cmd_take)
        begin
            unique case (cmd_op_s)
                OP_LOAD_CARD:
                begin
                    next_count = {cmd_data_s[CARD_W-1:0], count[CHAN_W-1:0]};
                end
                OP_LOAD_CHANNEL:
                begin
                    next_count = {count[COUNT_W-1:CHAN_W], cmd_data_s[CHAN_W-1:0]};
                end
                OP_INCREMENT:
                begin
                    next_count = count + 9'h001;
                end
                OP_WRITE_SPI:
                begin
                    next_spi_wr = 1'b1;
                    next_spi_data = cmd_data_s;
                end
            endcase
        end
        else if (scan_step)
        begin
            // one channel per scan clock, wraps after 512
            next_count = count + 9'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= '0;
            spi_wr <= 1'b0;
            spi_data <= SPI_RESET;
        end
        else
        begin
            count <= next_count;
            spi_wr <= next_spi_wr;
            spi_data <= next_spi_data;
        end
    end

    // ************************************************************
    // select outputs
    // ************************************************************
    function automatic logic [CARD_W-1:0] swap_card(input logic [CARD_W-1:0] v);
        logic [CARD_W-1:0] r;
        r = '0;
        for (int i = 0; i < CARD_W; i++)
        begin
            r[i] = v[CARD_W-1-i];
        end
        return r;
    endfunction

    function automatic logic [CHAN_W-1:0] swap_chan(input logic [CHAN_W-1:0] v);
        logic [CHAN_W-1:0] r;
        r = '0;
        for (int i = 0; i < CHAN_W; i++)
        begin
            r[i] = v[CHAN_W-1-i];
        end
        return r;
    endfunction

    logic [CARD_W-1:0] next_card_bus;
    logic [CHAN_W-1:0] next_chan_bus;
    logic [CARD_W-1:0] next_video_sel;
    logic [MUX8_SEL_W-1:0] next_mux8_sel;
    logic [MUX6_SEL_W-1:0] next_mux6_sel;

    always_comb
    begin
        next_card_bus = swap_card(next_count[COUNT_W-1:CHAN_W]);
        next_chan_bus = swap_chan(next_count[CHAN_W-1:0]);
        // card stage picks 1 of 16
        next_video_sel = next_count[COUNT_W-1:CHAN_W];
        // low bits pick the 8-way input
        next_mux8_sel = next_count[MUX8_SEL_W-1:0];
        // fifth selector holds only reference levels, never reached by the scan
        next_mux6_sel = {1'b0, next_count[CHAN_W-1:MUX8_SEL_W]};
        // counter upper bits follow frequency order
    end

    // ************************************************************
    // accumulate, discharge and fault lines
    // ************************************************************
    logic [DISCHARGE_CNT_W-1:0] dis_cnt;
    logic [DISCHARGE_CNT_W-1:0] next_dis_cnt;
    logic next_accumulate_bp;
    logic next_discharge_bp;
    logic next_detector_connect;
    logic next_error_readback;

    always_comb
    begin
        next_dis_cnt = '0;
        next_discharge_bp = 1'b0;
        if (discharge_s)
        begin
            // pulse follows input, cut at nominal length
            if (dis_cnt < DISCHARGE_CNT_W'(DISCHARGE_MAX_CYCLES))
            begin
                next_dis_cnt = dis_cnt + 16'h0001;
                next_discharge_bp = 1'b1;
            end
            else
            begin
                next_dis_cnt = dis_cnt;
            end
        end
        next_accumulate_bp = accumulate_s;
        next_detector_connect = accumulate_s;
        next_error_readback = |card_fault_s || |pll_unlock_s;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dis_cnt <= '0;
            card_bus <= '0;
            chan_bus <= '0;
            video_sel <= '0;
            mux8_sel <= '0;
            mux6_sel <= '0;
            accumulate_bp <= 1'b0;
            discharge_bp <= 1'b0;
            detector_connect <= 1'b0;
            error_readback <= 1'b0;
        end
        else
        begin
            dis_cnt <= next_dis_cnt;
            card_bus <= next_card_bus;
            chan_bus <= next_chan_bus;
            video_sel <= next_video_sel;
            mux8_sel <= next_mux8_sel;
            mux6_sel <= next_mux6_sel;
            accumulate_bp <= next_accumulate_bp;
            discharge_bp <= next_discharge_bp;
            detector_connect <= next_detector_connect;
            error_readback <= next_error_readback;
        end
    end

    // ************************************************************
    // serial fan-out
    // ************************************************************
    spi_write_if spi_link();

    assign spi_link.wr = spi_wr;
    assign spi_link.data = spi_data;

    spi_fanout u_spi_fanout
    (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wr_port(spi_link.fan),
        .conv_set(conv_spi),
        .filt_set(filt_spi)
    );

endmodule

// *** core/scan_mux_pkg.sv ***
// constants shared by the crate scan sequencer and its serial fan-out
// assumes a 100 MHz system clock; all link pins arrive asynchronously
package scan_mux_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHANNEL_PERIOD_NS = 1000;
    localparam int DISCHARGE_NOM_US = 100;
    // longest time, so rounded down; never below one cycle
    localparam int DISCHARGE_CYCLES_CALC = (DISCHARGE_NOM_US * 1000) / CLK_PERIOD_NS;
    localparam int DISCHARGE_CYCLES = (DISCHARGE_CYCLES_CALC < 1) ? 1 : DISCHARGE_CYCLES_CALC;
    localparam int DISCHARGE_CNT_W = 16;

    // ************************************************************
    // crate geometry
    // ************************************************************
    localparam int NUM_CHANNELS = 512;
    localparam int NUM_CARDS = 16;
    localparam int CHANS_PER_CARD = 32;
    localparam int MUX8_WAYS = 8;
    localparam int CARD_W = 4;
    localparam int CHAN_W = 5;
    localparam int COUNT_W = 9;
    localparam int MUX8_SEL_W = 3;
    localparam int MUX6_SEL_W = 3;
    localparam int NUM_PLLS = 4;

    // ************************************************************
    // control interface
    // ************************************************************
    localparam int CMD_DATA_W = 8;
    typedef enum logic [1:0]
    {
        OP_LOAD_CARD = 2'h0,
        OP_LOAD_CHANNEL = 2'h1,
        OP_INCREMENT = 2'h2,
        OP_WRITE_SPI = 2'h3
    } cmd_op_type;

    // ************************************************************
    // serial fan-out register layout, two sets of four lines
    // ************************************************************
    localparam int SPI_REG_W = 8;
    localparam int SPI_SET_W = 4;
    localparam int SPI_CLOCK_BIT = 0;
    localparam int SPI_ENABLE_BIT = 1;
    localparam int SPI_DATA_BIT = 2;
    localparam int SPI_ADR_BIT = 3;
    localparam int SPI_CONV_LSB = 0;
    localparam int SPI_FILT_LSB = 4;
    localparam logic [7:0] SPI_RESET = 8'h00;

endpackage

// *** core/spi_fanout.sv ***
// eight-bit serial line register feeding converter and filter cards
// assumes writes arrive as one-cycle pulses on clk_sys
`timescale 1ns/1ps
module spi_fanout
    import scan_mux_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // async reset
    spi_write_if.fan wr_port, // register write
    output logic [SPI_SET_W-1:0] conv_set, // converter card lines
    output logic [SPI_SET_W-1:0] filt_set // filter card lines
);

    logic [SPI_REG_W-1:0] spi_reg;
    logic [SPI_REG_W-1:0] next_spi_reg;

    always_comb
    begin
        next_spi_reg = spi_reg;
        if (wr_port.wr)
        begin
            next_spi_reg = wr_port.data;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            spi_reg <= SPI_RESET;
        end
        else
        begin
            spi_reg <= next_spi_reg;
        end
    end

    assign conv_set = spi_reg[SPI_CONV_LSB +: SPI_SET_W];
    assign filt_set = spi_reg[SPI_FILT_LSB +: SPI_SET_W];

endmodule

// *** core/spi_write_if.sv ***
// carries one register write from the sequencer to the serial fan-out
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface spi_write_if;
    import scan_mux_pkg::*;
    logic wr;
    logic [SPI_REG_W-1:0] data;
    modport ctrl
    (
        output wr,
        output data
    );
    modport fan
    (
        input wr,
        input data
    );
endinterface

// *** test/filter_channel_scan_mux_checker.sv ***
// port-level assertions for the crate scan sequencer
// assumes bind onto filter_channel_scan_mux, single clock domain
`timescale 1ns/1ps
module filter_channel_scan_mux_checker
    import scan_mux_pkg::*;
#(
    parameter int DISCHARGE_MAX_CYCLES = DISCHARGE_CYCLES
)
(
    input wire logic clk_sys, // clock
    input wire logic arst_n, // reset
    input wire logic scan_clk, // pin
    input wire logic scan_en, // pin
    input wire logic accumulate_in, // pin
    input wire logic discharge_in, // pin
    input wire logic cmd_strobe, // pin
    input wire logic [1:0] cmd_op, // pin
    input wire logic [CMD_DATA_W-1:0] cmd_data, // pin
    input wire logic [NUM_CARDS-1:0] card_fault, // pin
    input wire logic [NUM_PLLS-1:0] pll_unlock, // pin
    input wire logic [CARD_W-1:0] card_bus, // out
    input wire logic [CHAN_W-1:0] chan_bus, // out
    input wire logic [CARD_W-1:0] video_sel, // out
    input wire logic [MUX8_SEL_W-1:0] mux8_sel, // out
    input wire logic [MUX6_SEL_W-1:0] mux6_sel, // out
    input wire logic accumulate_bp, // out
    input wire logic discharge_bp, // out
    input wire logic detector_connect, // out
    input wire logic [SPI_SET_W-1:0] conv_spi, // out
    input wire logic [SPI_SET_W-1:0] filt_spi, // out
    input wire logic error_readback // out
);
    // ************************************************************
    // helper state
    // ************************************************************
    wire logic [COUNT_W-1:0] cnt = {video_sel, mux6_sel[1:0], mux8_sel};
    logic [7:0] cmd_hist;
    logic [7:0] next_cmd_hist;
    logic [DISCHARGE_CNT_W-1:0] dump_len;
    logic [DISCHARGE_CNT_W-1:0] next_dump_len;
    always_comb
    begin
        next_cmd_hist = {cmd_hist[6:0], cmd_strobe};
        next_dump_len = discharge_bp ? dump_len + 1'b1 : '0;
    end
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_hist <= '0;
            dump_len <= '0;
        end
        else
        begin
            cmd_hist <= next_cmd_hist;
            dump_len <= next_dump_len;
        end
    end
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence step_req;
        $rose(scan_clk) && scan_en && !accumulate_in && !discharge_in;
    endsequence
    sequence spi_req;
        $rose(cmd_strobe) && cmd_op == OP_WRITE_SPI;
    endsequence
    AST_CARD_SWAP: assert property (card_bus == {video_sel[0], video_sel[1], video_sel[2], video_sel[3]})
        else $error("card bus not swapped");
    AST_CHAN_SWAP: assert property (chan_bus == {mux8_sel[0], mux8_sel[1], mux8_sel[2], mux6_sel[0], mux6_sel[1]})
        else $error("channel bus not swapped");
    AST_MUX6_RANGE: assert property (mux6_sel[2] == 1'b0)
        else $error("reference selector scanned");
    AST_ISOLATE: assert property (!accumulate_in [*4] |-> !detector_connect)
        else $error("detector link outside accumulation");
    AST_HOLD_ACC: assert property (accumulate_bp && $past(accumulate_bp) && cmd_hist == 8'h00 |-> $stable(cnt))
        else $error("selection moved during accumulation");
    AST_STEP_ONE: assert property ($changed(cnt) && cmd_hist == 8'h00 |-> cnt == $past(cnt) + 9'h001 || cnt == 9'h000)
        else $error("channel stepped by more than one");
    AST_STEP_TIME: assert property (step_req |-> ##[2:5] $changed(cnt))
        else $error("scan step not taken");
    AST_SPI_LOAD: assert property (spi_req |-> ##[4:5] {filt_spi, conv_spi} == $past(cmd_data, 4))
        else $error("serial register not loaded");
    AST_DUMP_MAX: assert property (dump_len <= DISCHARGE_MAX_CYCLES)
        else $error("discharge pulse too long");
    AST_ERROR: assert property ($stable({card_fault, pll_unlock}) [*4] |-> error_readback == |{card_fault, pll_unlock})
        else $error("error readback wrong");
endmodule
bind filter_channel_scan_mux filter_channel_scan_mux_checker #(.DISCHARGE_MAX_CYCLES(DISCHARGE_MAX_CYCLES))
    i_filter_channel_scan_mux_checker (.clk_sys, .arst_n, .scan_clk, .scan_en, .accumulate_in, .discharge_in,
    .cmd_strobe, .cmd_op, .cmd_data, .card_fault, .pll_unlock, .card_bus, .chan_bus, .video_sel, .mux8_sel,
    .mux6_sel, .accumulate_bp, .discharge_bp, .detector_connect, .conv_spi, .filt_spi, .error_readback);

// *** test/scan_link_model.sv ***
// behavioural integrator-card controller on the scan link pins
// assumes one task runs at a time; pins rest low between frames
`timescale 1ns/1ps
module scan_link_model
#(
    parameter int ACC_NS = 25000000, // accumulation span, ns
    parameter int DUMP_NS = 100000 // discharge span, ns
)
(
    output logic scan_clk, // scan clock pin
    output logic scan_en, // scan enable pin
    output logic frame_sync, // frame sync pin
    output logic accumulate_in, // accumulate pin
    output logic discharge_in // discharge pin
);
    initial
    begin
        scan_clk = 1'b0;
        scan_en = 1'b0;
        frame_sync = 1'b0;
        accumulate_in = 1'b0;
        discharge_in = 1'b0;
    end
    task automatic steps(input int n, input bit sync);
        if (sync)
        begin
            frame_sync = 1'b1;
            #80;
            frame_sync = 1'b0;
            #80;
        end
        scan_en = 1'b1;
        // odd offset keeps link edges off the system clock edges
        #43;
        repeat (n)
        begin
            scan_clk = 1'b1;
            #40;
            scan_clk = 1'b0;
            #40;
        end
        #80;
        scan_en = 1'b0;
    endtask
    task automatic integrate(input bit clocked);
        accumulate_in = 1'b1;
        scan_en = clocked;
        repeat (ACC_NS / 80)
        begin
            scan_clk = clocked;
            #40;
            scan_clk = 1'b0;
            #40;
        end
        accumulate_in = 1'b0;
        scan_en = 1'b0;
        #80;
    endtask
    task automatic dump();
        discharge_in = 1'b1;
        #(DUMP_NS);
        discharge_in = 1'b0;
        #80;
    endtask
    task automatic frame(input int n, input bit blank);
        integrate(1'b0);
        if (!blank)
            steps(n, 1'b1);
        dump();
    endtask
endmodule

// *** test/tb_filter_channel_scan_mux.sv ***
// self-checking bench for the crate scan sequencer
// assumes the link model owns the scan pins; bench owns command and fault pins
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_filter_channel_scan_mux;
    import scan_mux_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic scan_clk, scan_en, frame_sync, accumulate_in, discharge_in;
    logic cmd_strobe = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [CMD_DATA_W-1:0] cmd_data = 8'h00;
    logic [NUM_CARDS-1:0] card_fault = 16'h0000;
    logic [NUM_PLLS-1:0] pll_unlock = 4'h0;
    logic [CARD_W-1:0] card_bus, video_sel;
    logic [CHAN_W-1:0] chan_bus;
    logic [MUX8_SEL_W-1:0] mux8_sel;
    logic [MUX6_SEL_W-1:0] mux6_sel;
    logic accumulate_bp, discharge_bp, detector_connect, error_readback;
    logic [SPI_SET_W-1:0] conv_spi, filt_spi;
    logic [COUNT_W-1:0] v;
    logic [7:0] d;
    logic [COUNT_W-1:0] edge_vals [3] = '{9'h1FF, 9'h01F, 9'h0FF};
    logic [7:0] spi_vals [4] = '{8'h88, 8'h0F, 8'hF0, 8'h00};
    int failures = 0;
    int compares = 0;
    always #5 clk_sys = ~clk_sys;
    filter_channel_scan_mux #(.DISCHARGE_MAX_CYCLES(20)) i_filter_channel_scan_mux (.clk_sys, .arst_n, .scan_clk,
        .scan_en, .frame_sync, .accumulate_in, .discharge_in, .cmd_strobe, .cmd_op, .cmd_data, .card_fault,
        .pll_unlock, .card_bus, .chan_bus, .video_sel, .mux8_sel, .mux6_sel, .accumulate_bp, .discharge_bp,
        .detector_connect, .conv_spi, .filt_spi, .error_readback);
    scan_link_model #(.ACC_NS(2000), .DUMP_NS(300)) i_scan_link_model (.scan_clk, .scan_en, .frame_sync,
        .accumulate_in, .discharge_in);
    task automatic give_verdict();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check_count(input logic [COUNT_W-1:0] e);
        `CHK({video_sel, mux6_sel[1:0], mux8_sel}, e)
        `CHK(chan_bus, {e[0], e[1], e[2], e[3], e[4]})
        `CHK(card_bus, {e[5], e[6], e[7], e[8]})
    endtask
    // strobe held four cycles; op and data settle a cycle ahead
    task automatic cmd(input logic [1:0] op, input logic [7:0] dat);
        @(negedge clk_sys);
        cmd_op = op;
        cmd_data = dat;
        @(negedge clk_sys);
        cmd_strobe = 1'b1;
        repeat (4) @(negedge clk_sys);
        cmd_strobe = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask
    initial
    begin
        #300000;
        failures++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'h14A7));
        repeat (16) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
            card_fault = (i < 2) ? 16'h0000 : 16'($urandom);
            pll_unlock = (i % 3 == 1) ? 4'($urandom | 1) : 4'h0;
            repeat (5) @(negedge clk_sys);
            `CHK(error_readback, |{card_fault, pll_unlock})
        end
        card_fault = 16'h0000;
        pll_unlock = 4'h0;
        for (int k = 0; k < 8; k++)
        begin
            v = (k < 3) ? edge_vals[k] : 9'($urandom);
            cmd(OP_LOAD_CARD, {4'h0, v[8:5]});
            cmd(OP_LOAD_CHANNEL, {3'h0, v[4:0]});
            check_count(v);
            cmd(OP_INCREMENT, 8'h00);
            check_count(v + 9'h001);
        end
        for (int k = 0; k < 6; k++)
        begin
            d = (k < 4) ? spi_vals[k] : 8'($urandom);
            cmd(OP_WRITE_SPI, d);
            `CHK({filt_spi, conv_spi}, d)
        end
        i_scan_link_model.frame(5, 1'b0);
        check_count(9'h005);
        i_scan_link_model.frame(7, 1'b1);
        check_count(9'h005);
        fork
            i_scan_link_model.integrate(1'b1);
            begin
                repeat (10) @(negedge clk_sys);
                `CHK(detector_connect, 1'b1)
                `CHK(accumulate_bp, 1'b1)
            end
        join
        `CHK(accumulate_bp, 1'b0)
        `CHK(detector_connect, 1'b0)
        check_count(9'h005);
        i_scan_link_model.steps(512, 1'b1);
        check_count(9'h000);
        i_scan_link_model.steps(511, 1'b1);
        check_count(9'h1FF);
        i_scan_link_model.steps(1, 1'b0);
        check_count(9'h000);
        // input outlasts the cap, so the output must drop first
        fork
            i_scan_link_model.dump();
            begin
                repeat (10) @(negedge clk_sys);
                `CHK(discharge_bp, 1'b1)
                repeat (18) @(negedge clk_sys);
                `CHK(discharge_bp, 1'b0)
            end
        join
        // mid-run reset must clear a loaded selection and the serial register
        cmd(OP_LOAD_CHANNEL, 8'h11);
        check_count(9'h011);
        arst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        check_count(9'h000);
        `CHK({filt_spi, conv_spi}, 8'h00)
        `CHK(discharge_bp, 1'b0)
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check_count(9'h000);
        give_verdict();
    end
endmodule
